// ===== src/lfi_pkg.sv
/*
  Shared constants and types for the loop fault isolation pair: the field
  node end and the loop controller end.
  Assumes one 50 MHz system clock shared by both ends.
*/
package lfi_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned ISO_TIMEOUT_S = 7200;        // Two hours
    localparam longint unsigned ISO_TIMEOUT_CYC = longint'(ISO_TIMEOUT_S) * CLK_HZ;
    localparam int unsigned LOSS_MS = 3000;              // Heartbeat loss period
    localparam int unsigned LOSS_CYC = LOSS_MS * (CLK_HZ / 1000);
    localparam int unsigned LISTEN_MS = 2000;            // Listen time per side
    localparam int unsigned LISTEN_CYC = LISTEN_MS * (CLK_HZ / 1000);
    localparam int unsigned HB_PERIOD_MS = 100;          // Heartbeat spacing
    localparam int unsigned HB_PERIOD_CYC = HB_PERIOD_MS * (CLK_HZ / 1000);
    localparam int unsigned STAMP_S = 1;                 // Time stamp interval
    localparam int unsigned STAMP_CYC = STAMP_S * CLK_HZ;
    localparam int unsigned STATUS_MS = 1000;            // Node status interval
    localparam int unsigned STATUS_CYC = STATUS_MS * (CLK_HZ / 1000);
    localparam int unsigned OFFLINE_MS = 5000;           // Node silence before offline
    localparam int unsigned OFFLINE_CYC = OFFLINE_MS * (CLK_HZ / 1000);

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int TIME_W = 32;
    localparam int STAT_W = 8;
    localparam int COND_W = 8;
    localparam logic [1:0] SW_CLOSED = 2'h3;             // Both switches closed

    // ----------------------------------------------------------------
    // Node isolation states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LFI_NORMAL  = 3'b000,
        LFI_OPEN_A  = 3'b001,
        LFI_OPEN_B  = 3'b010,
        LFI_LOCKOUT = 3'b011
    } lfi_state_t;
endpackage

// ===== src/lfi_loop_if.sv
/*
  Loop interface joining one field node and the loop controller.
  Two loop ports, A and B; the testbench models the cabling and breaks.
*/
`timescale 1ns/1ps
interface lfi_loop_if;
    logic hb_a;                         // Heartbeat pulse seen on port A
    logic hb_b;                         // Heartbeat pulse seen on port B
    logic [lfi_pkg::TIME_W-1:0] hb_time;  // Time and date carried in the heartbeat
    logic hb_time_valid;                // Heartbeat carries a time stamp
    logic stat_a;                       // Node status pulse out of port A
    logic stat_b;                       // Node status pulse out of port B
    logic [lfi_pkg::STAT_W-1:0] stat_data;

    modport node
    (
        input hb_a, hb_b, hb_time, hb_time_valid,
        output stat_a, stat_b, stat_data
    );
    modport ctrl
    (
        output hb_a, hb_b, hb_time, hb_time_valid,
        input stat_a, stat_b, stat_data
    );
endinterface

// ===== src/lfi_node.sv
/*
  Field node end: heartbeat loss detection, alternating port isolation,
  two-hour lockout, status transmission.
  Assumes heartbeat pulses arrive synchronous to sys_clk and that hb_a/hb_b
  already reflect the state of this node's switches as modelled outside.
*/
`timescale 1ns/1ps
module lfi_node #(
    parameter int unsigned LOSS_CYC = lfi_pkg::LOSS_CYC,
    parameter int unsigned LISTEN_CYC = lfi_pkg::LISTEN_CYC,
    parameter longint unsigned TIMEOUT_CYC = lfi_pkg::ISO_TIMEOUT_CYC,
    parameter int unsigned STATUS_CYC = lfi_pkg::STATUS_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    lfi_loop_if.node loop,
    input wire logic [lfi_pkg::STAT_W-1:0] status_in,
    output logic sw_closed_a,
    output logic sw_closed_b,
    output logic isolating,
    output logic locked_out,
    output logic [lfi_pkg::TIME_W-1:0] stamp_time
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    lfi_pkg::lfi_state_t state;
    lfi_pkg::lfi_state_t next_state;
    logic [31:0] loss_cnt;
    logic [31:0] listen_cnt;
    logic [43:0] iso_cnt;
    logic [31:0] stat_cnt;
    logic hb_any;
    logic hb_heard;
    logic loss_done;
    logic listen_done;
    logic iso_done;

    assign hb_any = loop.hb_a | loop.hb_b;
    assign hb_heard = (state == lfi_pkg::LFI_OPEN_A && loop.hb_b) ||
                      (state == lfi_pkg::LFI_OPEN_B && loop.hb_a);
    assign loss_done = (loss_cnt >= LOSS_CYC - 1);
    assign listen_done = (listen_cnt >= LISTEN_CYC - 1);
    assign iso_done = (iso_cnt >= 44'(TIMEOUT_CYC - 1));

    // ----------------------------------------------------------------
    // Heartbeat loss timer
    // ----------------------------------------------------------------
    // Restarts on every heartbeat so only a continuous gap counts
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            loss_cnt <= 32'h0;
        else if (hb_any || state != lfi_pkg::LFI_NORMAL)
            loss_cnt <= 32'h0;
        else if (!loss_done)
            loss_cnt <= loss_cnt + 32'h1;
    end

    // Per-side listen timer, restarted at each side change
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            listen_cnt <= 32'h0;
        else if (next_state != state || hb_heard)
            listen_cnt <= 32'h0;
        else if (state == lfi_pkg::LFI_OPEN_A || state == lfi_pkg::LFI_OPEN_B)
            listen_cnt <= listen_cnt + 32'h1;
    end

    // Two-hour routine timer, runs while searching; each heartbeat heard restarts it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            iso_cnt <= 44'h0;
        else if ((state == lfi_pkg::LFI_OPEN_A || state == lfi_pkg::LFI_OPEN_B) && !hb_heard)
            iso_cnt <= iso_cnt + 44'h1;
        else
            iso_cnt <= 44'h0;
    end

    // ----------------------------------------------------------------
    // Isolation state machine
    // ----------------------------------------------------------------
    // Open A listens on B; open B listens on A
    always_comb
    begin
        next_state = state;
        case (state)
            lfi_pkg::LFI_NORMAL:
                if (loss_done && !hb_any)
                    next_state = lfi_pkg::LFI_OPEN_A;
            lfi_pkg::LFI_OPEN_A:
                if (loop.hb_b)
                    next_state = lfi_pkg::LFI_OPEN_A;
                else if (iso_done)
                    next_state = lfi_pkg::LFI_LOCKOUT;
                else if (listen_done)
                    next_state = lfi_pkg::LFI_OPEN_B;
            lfi_pkg::LFI_OPEN_B:
                if (loop.hb_a)
                    next_state = lfi_pkg::LFI_OPEN_B;
                else if (iso_done)
                    next_state = lfi_pkg::LFI_LOCKOUT;
                else if (listen_done)
                    next_state = lfi_pkg::LFI_OPEN_A;
            lfi_pkg::LFI_LOCKOUT:
                if (hb_any)
                    next_state = lfi_pkg::LFI_NORMAL;
            default:
                next_state = lfi_pkg::LFI_NORMAL;
        endcase
    end

    // A found heartbeat freezes the side: both search timers restart at each heartbeat heard
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state <= lfi_pkg::LFI_NORMAL;
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // Switch drive and status flags
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sw_closed_a <= lfi_pkg::SW_CLOSED[0];
            sw_closed_b <= lfi_pkg::SW_CLOSED[1];
            isolating <= 1'b0;
            locked_out <= 1'b0;
        end
        else
        begin
            sw_closed_a <= (next_state != lfi_pkg::LFI_OPEN_A);
            sw_closed_b <= (next_state != lfi_pkg::LFI_OPEN_B);
            isolating <= (next_state == lfi_pkg::LFI_OPEN_A) ||
                         (next_state == lfi_pkg::LFI_OPEN_B);
            locked_out <= (next_state == lfi_pkg::LFI_LOCKOUT);
        end
    end

    // Keep the last time stamp from the heartbeat for event logging
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            stamp_time <= '0;
        else if (hb_any && loop.hb_time_valid)
            stamp_time <= loop.hb_time;
    end

    // ----------------------------------------------------------------
    // Status transmission
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            stat_cnt <= 32'h0;
        else if (stat_cnt >= STATUS_CYC - 1)
            stat_cnt <= 32'h0;
        else
            stat_cnt <= stat_cnt + 32'h1;
    end

    // Status goes out of every closed port, one-cycle pulse
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            loop.stat_a <= 1'b0;
            loop.stat_b <= 1'b0;
            loop.stat_data <= '0;
        end
        else
        begin
            loop.stat_a <= (stat_cnt >= STATUS_CYC - 1) && sw_closed_a;
            loop.stat_b <= (stat_cnt >= STATUS_CYC - 1) && sw_closed_b;
            loop.stat_data <= status_in;
        end
    end
endmodule // lfi_node

// ===== src/lfi_ctrl.sv
/*
  Loop controller end: heartbeat out of both ports with a time stamp each
  second, node offline flag, latched conditions and reset push handling.
  Assumes one node on the loop and synchronous inputs.
*/
`timescale 1ns/1ps
module lfi_ctrl #(
    parameter int unsigned HB_CYC = lfi_pkg::HB_PERIOD_CYC,
    parameter int unsigned STAMP_CYC = HB_CYC * (lfi_pkg::STAMP_CYC / lfi_pkg::HB_PERIOD_CYC),
    parameter int unsigned OFFLINE_CYC = HB_CYC * (lfi_pkg::OFFLINE_CYC / lfi_pkg::HB_PERIOD_CYC)
)
(
    input wire logic sys_clk,
    input wire logic rst,
    lfi_loop_if.ctrl loop,
    input wire logic [lfi_pkg::TIME_W-1:0] rtc_time,
    input wire logic [lfi_pkg::COND_W-1:0] cond_active,
    input wire logic reset_push,
    output logic node_offline,
    output logic [lfi_pkg::COND_W-1:0] cond_latched,
    output logic [lfi_pkg::STAT_W-1:0] node_status
);
    // ----------------------------------------------------------------
    // Heartbeat and time stamp
    // ----------------------------------------------------------------
    logic [31:0] hb_cnt;
    logic [31:0] stamp_cnt;
    logic [31:0] off_cnt;
    logic hb_tick;
    logic stamp_due;

    assign hb_tick = (hb_cnt >= HB_CYC - 1);

    // Heartbeat period and one-second stamp counters
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hb_cnt <= 32'h0;
            stamp_cnt <= 32'h0;
        end
        else
        begin
            hb_cnt <= hb_tick ? 32'h0 : hb_cnt + 32'h1;
            stamp_cnt <= (stamp_cnt >= STAMP_CYC - 1) ? 32'h0 : stamp_cnt + 32'h1;
        end
    end

    // Stamp request held until the next heartbeat carries it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            stamp_due <= 1'b0;
        else if (stamp_cnt >= STAMP_CYC - 1)
            stamp_due <= 1'b1;
        else if (hb_tick)
            stamp_due <= 1'b0;
    end

    // Same heartbeat pulse out of both ports
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            loop.hb_a <= 1'b0;
            loop.hb_b <= 1'b0;
            loop.hb_time <= '0;
            loop.hb_time_valid <= 1'b0;
        end
        else
        begin
            loop.hb_a <= hb_tick;
            loop.hb_b <= hb_tick;
            loop.hb_time <= rtc_time;
            loop.hb_time_valid <= hb_tick && stamp_due;
        end
    end

    // ----------------------------------------------------------------
    // Node reachability
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            off_cnt <= 32'h0;
            node_status <= '0;
        end
        else if (loop.stat_a || loop.stat_b)
        begin
            off_cnt <= 32'h0;
            node_status <= loop.stat_data;
        end
        else if (off_cnt < OFFLINE_CYC)
            off_cnt <= off_cnt + 32'h1;
    end

    // ----------------------------------------------------------------
    // Latched conditions
    // ----------------------------------------------------------------
    // Offline latches; cleared only by an accepted reset push
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            node_offline <= 1'b0;
        else if (off_cnt >= OFFLINE_CYC)
            node_offline <= 1'b1;
        else if (reset_push && cond_active == '0)
            node_offline <= 1'b0;
    end

    // Set wins over clear; push ignored while any condition is active
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cond_latched <= '0;
        else if (reset_push && cond_active == '0 && off_cnt < OFFLINE_CYC)
            cond_latched <= '0;
        else
            cond_latched <= cond_latched | cond_active;
    end
endmodule // lfi_ctrl

// ===== tb/lfi_loop_chk.sv
/*
  Checker for the loop between the controller and one field node.
  Assumes the bench hands it the heartbeat lines as the controller drives them
  and the status lines as the node drives them, with HB_CYC=4, a stamp every
  40 cycles and STATUS_CYC=5.
*/
`timescale 1ns/1ps
module lfi_loop_chk
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hb_a,
    input wire logic hb_b,
    input wire logic [lfi_pkg::TIME_W-1:0] hb_time,
    input wire logic hb_time_valid,
    input wire logic stat_a,
    input wire logic stat_b,
    input wire logic [lfi_pkg::STAT_W-1:0] stat_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Heartbeat and stamp timing
    // ------------------------------------------------------------
    AST_HB_BOTH: assert property (hb_a == hb_b)
        else $error("heartbeat differs between ports");
    AST_HB_PERIOD: assert property (hb_a |=> (!hb_a) [*3] ##1 hb_a)
        else $error("heartbeat spacing wrong");
    AST_HB_ALIVE: assert property ((!hb_a) [*5] |=> hb_a)
        else $error("heartbeat stopped");
    AST_STAMP_WITH_HB: assert property (hb_time_valid |-> hb_a && hb_b)
        else $error("stamp without heartbeat");
    AST_STAMP_QUIET: assert property (hb_time_valid |=> (!hb_time_valid) [*8])
        else $error("stamps too close");
    AST_STAMP_DUE: assert property (hb_a |-> ##[0:40] hb_time_valid)
        else $error("stamp missing");

    // ------------------------------------------------------------
    // Node status traffic
    // ------------------------------------------------------------
    AST_STAT_DUE: assert property ((stat_a || stat_b) |-> ##[1:6] (stat_a || stat_b))
        else $error("status stopped");
    AST_STAT_PULSE: assert property (stat_a |=> !stat_a)
        else $error("status pulse too long");

    // Main scenarios seen
    CV_STAMP: cover property (hb_time_valid && hb_time != '0);
    CV_STAT_DATA: cover property ((stat_a || stat_b) && stat_data != '0);
    CV_ONE_SIDE: cover property (stat_b && !stat_a);
    CV_BOTH: cover property (stat_a && stat_b);
endmodule // lfi_loop_chk

// ===== tb/loop_fault_isolation_test.sv
/*
  Self-checking bench for the node and controller pair.
  Assumes shortened counts and models the cabling: a break or an open switch
  blocks a port in both directions.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module loop_fault_isolation_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] status_in = 8'h3c;
    logic [31:0] rtc_time = 32'h1234_5678;
    logic [7:0] cond_active = 8'h00;
    logic reset_push = 1'b0;
    logic brk_a = 1'b0;
    logic brk_b = 1'b0;
    logic sw_closed_a, sw_closed_b, isolating, locked_out, node_offline;
    logic [31:0] stamp_time;
    logic [7:0] cond_latched, node_status;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    logic pa, pb;

    lfi_loop_if lc();
    lfi_loop_if ln();

    // ------------------------------------------------------------
    // Cabling between the two ends
    // ------------------------------------------------------------
    assign pa = !brk_a && sw_closed_a;
    assign pb = !brk_b && sw_closed_b;
    assign ln.hb_a = lc.hb_a && pa;
    assign ln.hb_b = lc.hb_b && pb;
    assign ln.hb_time = lc.hb_time;
    assign ln.hb_time_valid = lc.hb_time_valid;
    assign lc.stat_a = ln.stat_a && pa;
    assign lc.stat_b = ln.stat_b && pb;
    assign lc.stat_data = ln.stat_data;

    lfi_node #(.LOSS_CYC(20), .LISTEN_CYC(10), .TIMEOUT_CYC(200), .STATUS_CYC(5)) lfi_node_inst
    (
        .sys_clk(sys_clk), .rst(rst), .loop(ln), .status_in(status_in),
        .sw_closed_a(sw_closed_a), .sw_closed_b(sw_closed_b), .isolating(isolating),
        .locked_out(locked_out), .stamp_time(stamp_time)
    );
    lfi_ctrl #(.HB_CYC(4)) lfi_ctrl_inst
    (
        .sys_clk(sys_clk), .rst(rst), .loop(lc), .rtc_time(rtc_time),
        .cond_active(cond_active), .reset_push(reset_push), .node_offline(node_offline),
        .cond_latched(cond_latched), .node_status(node_status)
    );
    lfi_loop_chk lfi_loop_chk_inst
    (
        .sys_clk(sys_clk), .rst(rst), .hb_a(lc.hb_a), .hb_b(lc.hb_b),
        .hb_time(lc.hb_time), .hb_time_valid(lc.hb_time_valid),
        .stat_a(ln.stat_a), .stat_b(ln.stat_b), .stat_data(ln.stat_data)
    );

    // Clock and hang guard
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic push();
        reset_push = 1'b1;
        step(1);
        reset_push = 1'b0;
        step(2);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        step(8);
        rst = 1'b0;
        // Normal loop: both closed, status and stamp delivered
        step(60);
        `CHK("sw_a", 1'b1, sw_closed_a)
        `CHK("sw_b", 1'b1, sw_closed_b)
        `CHK("status", 8'h3c, node_status)
        `CHK("stamp", 32'h1234_5678, stamp_time)
        `CHK("offline", 1'b0, node_offline)
        $display("test normal done");
        // Total loss: wait, isolate A, alternate, lock out
        brk_a = 1'b1;
        brk_b = 1'b1;
        step(14);
        `CHK("iso_early", 1'b0, isolating)
        for (int i = 0; i < 30 && isolating !== 1'b1; i++) step(1);
        `CHK("iso_a_open", 2'h1, {sw_closed_a, sw_closed_b})
        for (int i = 0; i < 14 && sw_closed_b !== 1'b0; i++) step(1);
        `CHK("iso_b_open", 2'h2, {sw_closed_a, sw_closed_b})
        for (int i = 0; i < 14 && sw_closed_a !== 1'b0; i++) step(1);
        `CHK("iso_a_again", 2'h1, {sw_closed_a, sw_closed_b})
        for (int i = 0; i < 230 && locked_out !== 1'b1; i++) step(1);
        `CHK("locked", 1'b1, locked_out)
        `CHK("lock_sw", 2'h3, {sw_closed_a, sw_closed_b})
        `CHK("lock_iso", 1'b0, isolating)
        `CHK("offline_set", 1'b1, node_offline)
        $display("test isolation done");
        // Heartbeat returns: routine armed again
        brk_a = 1'b0;
        brk_b = 1'b0;
        rtc_time = 32'h8765_4321;
        step(12);
        `CHK("rearm", 1'b0, locked_out)
        // Re-isolate, then heartbeat only through B: A stays open
        brk_a = 1'b1;
        brk_b = 1'b1;
        for (int i = 0; i < 40 && isolating !== 1'b1; i++) step(1);
        brk_b = 1'b0;
        status_in = 8'ha5;
        step(40);
        `CHK("single_sw", 2'h1, {sw_closed_a, sw_closed_b})
        `CHK("single_iso", 1'b1, isolating)
        `CHK("single_stat", 8'ha5, node_status)
        `CHK("single_stamp", 32'h8765_4321, stamp_time)
        $display("test single break done");
        // Latching and reset push rules
        cond_active = 8'h05;
        step(2);
        cond_active = 8'h01;
        step(2);
        `CHK("latched", 8'h05, cond_latched)
        push();
        `CHK("push_refused", 8'h05, cond_latched)
        `CHK("alarm_kept", 1'b1, cond_latched[0])
        cond_active = 8'h00;
        step(2);
        `CHK("held_after_clear", 8'h05, cond_latched)
        push();
        `CHK("push_taken", 8'h00, cond_latched)
        `CHK("offline_cleared", 1'b0, node_offline)
        $display("test latch done");
        end_sim();
    end
endmodule // loop_fault_isolation_test
